// ---- hw/irq_route_map.svh ----
// Contract
// - Pin-A second map bit 6 routes fuse IRQ status to pin A.
// - Pin-A second map bit 5 routes latched undervoltage to pin A.
// - Pin-A second map bit 4 routes latched overrange to pin A.
// - Pin-A second map bit 3 routes parity error status to pin A.
// - Pin-A second map bits 2..0 route triple, double, single tap to pin A.
// - Pin-B first map bits 7,6,5 route fuse busy, still, motion to pin B.
// - Pin-B first map bit 3 routes watermark, bit 2 overrun; bit 4 reserved.
// - First map bit 1 gates queue full per pin; zero enables, one disables.
// - Pin-B first map bit 0 routes sample ready to pin B.
// - Pin-B second map bit 7 routes fuse done; register resets to 0x80.
// - Pin-B second map bits 6..0 mirror the pin-A second map layout.
// - Queue config A bit 7 resets read pointer, write pointer, read state.
// - Channel tag enable prepends a 2-bit channel id to each sample.
// - With tag disabled only the 16-bit signed sample is returned.
// - Mode field bits 5:4 selects disabled, normal, stream, trigger.
// - Trigger mode only: bit 3 picks frame sync pin or activity.
// - Nine-bit level sets watermark once queue holds at least that many.
// - Watermark stays set until read; reading clears it.
// - Edge select latches flags on rising edge, else while status high.
// - Queue disabled is frozen; enabled queue operates.
`ifndef IRQ_ROUTE_MAP_SVH
`define IRQ_ROUTE_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_PIN_A_MAP_A   8'h2b
`define OFS_PIN_A_MAP_B   8'h2c
`define OFS_PIN_B_MAP_A   8'h2d
`define OFS_PIN_B_MAP_B   8'h2e
`define OFS_QUEUE_CFG_A   8'h30
`define OFS_QUEUE_CFG_B   8'h31
// ****************************************
// Reset values
// ****************************************
`define RST_PIN_A_MAP_A   8'h80
`define RST_PIN_A_MAP_B   8'h00
`define RST_PIN_B_MAP_A   8'h00
`define RST_PIN_B_MAP_B   8'h80
`define RST_QUEUE_CFG_A   8'h00
`define RST_QUEUE_CFG_B   8'h00
// ****************************************
// Field positions
// ****************************************
`define MAPA_BUSY    7
`define MAPA_STILL   6
`define MAPA_MOTION  5
`define MAPA_RSVD    4
`define MAPA_MARK    3
`define MAPA_OVFL    2
`define MAPA_FULL_N  1
`define MAPA_READY   0
`define MAPB_DONE    7
`define MAPB_FIRQ    6
`define MAPB_UV      5
`define MAPB_OVR     4
`define MAPB_PAR     3
`define MAPB_TAP3    2
`define MAPB_TAP2    1
`define MAPB_TAP1    0
`define QCA_PTR_RST  7
`define QCA_TAG      6
`define QCA_MODE_HI  5
`define QCA_MODE_LO  4
`define QCA_EXT_TRIG 3
`define QCA_LVL_HI   0
`define QCA_WMASK    8'hf9
// ****************************************
// Queue modes and size
// ****************************************
`define QMODE_OFF     2'h0
`define QMODE_NORMAL  2'h1
`define QMODE_STREAM  2'h2
`define QMODE_TRIGGER 2'h3
`define QUEUE_DEPTH   9'h140
`define QUEUE_LAST    9'h13f
`endif

// ---- hw/irq_route_pkg.sv ----
package irq_route_pkg;
  typedef struct packed {
    logic [1:0]  tag;
    logic [15:0] sample;
  } queue_word_t;

  typedef struct packed {
    logic fuse_busy;
    logic fuse_done_status;
    logic fuse_irq;
    logic undervolt;
    logic overrange;
    logic parity_fault;
    logic tap3;
    logic tap2;
    logic tap1;
    logic motion;
    logic still;
    logic sample_ready;
  } event_src_t;

  typedef enum logic {trg_armed, trg_capture} trig_state_t;
endpackage

// ---- hw/queue_store.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "irq_route_map.svh"
module queue_store
  import irq_route_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        flush,
  input  wire logic        push,
  input  wire logic        overwrite,
  input  var  queue_word_t wdata,
  input  wire logic        pop,
  output var  queue_word_t rdata,
  output logic [8:0]       count,
  output logic             full,
  output logic             overflow
);
  queue_word_t mem [0:319];
  logic [8:0]  wr_r;
  logic [8:0]  rd_r;
  logic [8:0]  cnt_r;
  logic [8:0]  wr_inc;
  logic [8:0]  rd_inc;
  logic        do_pop;
  logic        do_push;
  logic        drop_old;

  assign full     = (cnt_r == `QUEUE_DEPTH);
  assign count    = cnt_r;
  assign wr_inc   = (wr_r == `QUEUE_LAST) ? 9'h000 : wr_r + 9'h001;
  assign rd_inc   = (rd_r == `QUEUE_LAST) ? 9'h000 : rd_r + 9'h001;
  // Frozen while disabled: no push or pop and no storage activity; only a flush or reset moves pointers
  assign do_pop   = run && pop && (cnt_r != 9'h000);
  assign do_push  = run && push && (!full || overwrite || do_pop);
  assign drop_old = do_push && full && overwrite && !do_pop;
  assign overflow = run && push && full && !overwrite && !do_pop;

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_r] <= wdata;
    end
  end

  // Pointer reset wins over any traffic in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn || flush) begin
      wr_r  <= 9'h000;
      rd_r  <= 9'h000;
      cnt_r <= 9'h000;
      rdata <= '0;
    end else begin
      if (do_push) begin
        wr_r <= wr_inc;
      end
      if (do_pop || drop_old) begin
        rd_r <= rd_inc;
      end
      if (do_pop) begin
        rdata <= mem[rd_r];
      end
      if (do_push && !do_pop && !drop_old) begin
        cnt_r <= cnt_r + 9'h001;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 9'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/irq_route.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "irq_route_map.svh"
module irq_route
  import irq_route_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Control and status bits held elsewhere
  input  wire logic        queue_enable,
  input  wire logic        edge_latch_select,
  input  wire logic        status_read,
  input  wire logic        mark_read,
  output logic             undervolt_latched,
  output logic             overrange_latched,
  output logic             parity_latched,
  output logic             overflow_latched,
  output logic             level_mark,
  // Live sources
  input  var  event_src_t  src,
  input  wire logic        frame_sync_input,
  // Sample path
  input  wire logic        sample_push,
  input  wire logic [1:0]  sample_tag,
  input  wire logic [15:0] sample_data,
  input  wire logic        queue_pop,
  output logic [17:0]      queue_rdata,
  output logic [8:0]       queue_count,
  output logic             queue_full,
  // Pins
  output logic             irq_pin_a,
  output logic             irq_pin_b
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  pin_a_map_a_r;
  logic [7:0]  irq_pin_a_map_b_r;
  logic [7:0]  irq_pin_b_map_a_r;
  logic [7:0]  irq_pin_b_map_b_r;
  logic [7:0]  queue_config_a_r;
  logic [7:0]  queue_config_b_r;
  logic [7:0]  rd_mux;
  logic        wr_pa_a;
  logic        wr_pa_b;
  logic        wr_pb_a;
  logic        wr_pb_b;
  logic        wr_qa;
  logic        wr_qb;

  assign wr_pa_a = reg_wr && (reg_addr == `OFS_PIN_A_MAP_A);
  assign wr_pa_b = reg_wr && (reg_addr == `OFS_PIN_A_MAP_B);
  assign wr_pb_a = reg_wr && (reg_addr == `OFS_PIN_B_MAP_A);
  assign wr_pb_b = reg_wr && (reg_addr == `OFS_PIN_B_MAP_B);
  assign wr_qa   = reg_wr && (reg_addr == `OFS_QUEUE_CFG_A);
  assign wr_qb   = reg_wr && (reg_addr == `OFS_QUEUE_CFG_B);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_a_map_a_r     <= `RST_PIN_A_MAP_A;
      irq_pin_a_map_b_r <= `RST_PIN_A_MAP_B;
      irq_pin_b_map_a_r <= `RST_PIN_B_MAP_A;
      irq_pin_b_map_b_r <= `RST_PIN_B_MAP_B;
      queue_config_a_r  <= `RST_QUEUE_CFG_A;
      queue_config_b_r  <= `RST_QUEUE_CFG_B;
    end else begin
      if (wr_pa_a) begin
        pin_a_map_a_r <= reg_wdata;
      end
      if (wr_pa_b) begin
        irq_pin_a_map_b_r <= reg_wdata;
      end
      if (wr_pb_a) begin
        irq_pin_b_map_a_r <= reg_wdata;
      end
      if (wr_pb_b) begin
        irq_pin_b_map_b_r <= reg_wdata;
      end
      // Bits 2:1 are read-only zero
      if (wr_qa) begin
        queue_config_a_r <= reg_wdata & `QCA_WMASK;
      end
      if (wr_qb) begin
        queue_config_b_r <= reg_wdata;
      end
    end
  end

  assign rd_mux = (reg_addr == `OFS_PIN_A_MAP_A) ? pin_a_map_a_r :
                  (reg_addr == `OFS_PIN_A_MAP_B) ? irq_pin_a_map_b_r :
                  (reg_addr == `OFS_PIN_B_MAP_A) ? irq_pin_b_map_a_r :
                  (reg_addr == `OFS_PIN_B_MAP_B) ? irq_pin_b_map_b_r :
                  (reg_addr == `OFS_QUEUE_CFG_A) ? queue_config_a_r :
                  (reg_addr == `OFS_QUEUE_CFG_B) ? queue_config_b_r : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ****************************************
  // Queue configuration decode
  // ****************************************
  logic [1:0]  qmode;
  logic        channel_tag_enable;
  logic        queue_trigger_source;
  logic        ptr_reset;
  logic [8:0]  mark_level;

  assign ptr_reset            = queue_config_a_r[`QCA_PTR_RST];
  assign channel_tag_enable   = queue_config_a_r[`QCA_TAG];
  assign qmode                = queue_config_a_r[`QCA_MODE_HI:`QCA_MODE_LO];
  assign queue_trigger_source = queue_config_a_r[`QCA_EXT_TRIG];
  assign mark_level = {queue_config_a_r[`QCA_LVL_HI], queue_config_b_r};

  // ****************************************
  // Trigger sequencing
  // ****************************************
  trig_state_t trig_r;
  trig_state_t trig_nxt;
  logic        trig_hit;
  logic        in_trigger;

  // Source choice matters only in trigger mode
  assign in_trigger = (qmode == `QMODE_TRIGGER);
  assign trig_hit   = queue_trigger_source ? frame_sync_input : src.motion;

  always_comb begin
    trig_nxt = trig_r;
    unique case (trig_r)
      trg_armed: begin
        if (in_trigger && trig_hit) begin
          trig_nxt = trg_capture;
        end
      end
      trg_capture: begin
        if (!in_trigger) begin
          trig_nxt = trg_armed;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || ptr_reset) begin
      trig_r <= trg_armed;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // ****************************************
  // Queue storage
  // ****************************************
  queue_word_t wword;
  queue_word_t rword;
  logic        q_run;
  logic        q_push;
  logic        q_overwrite;
  logic        q_overflow;

  // Disabled mode and a cleared enable both leave the queue idle
  assign q_run  = queue_enable && (qmode != `QMODE_OFF);
  assign q_push = sample_push;
  // Stream and armed trigger keep the newest samples; capture stops at full
  assign q_overwrite = (qmode == `QMODE_STREAM) ||
                       (in_trigger && (trig_r == trg_armed));
  assign wword.tag    = sample_tag;
  assign wword.sample = sample_data;

  queue_store u_store (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (q_run),
    .flush     (ptr_reset),
    .push      (q_push),
    .overwrite (q_overwrite),
    .wdata     (wword),
    .pop       (queue_pop),
    .rdata     (rword),
    .count     (queue_count),
    .full      (queue_full),
    .overflow  (q_overflow)
  );

  // Tag is kept in storage so toggling the enable affects reads at once
  assign queue_rdata = channel_tag_enable ? {rword.tag, rword.sample}
                                          : {2'b00, rword.sample};

  // ****************************************
  // Latched flags
  // ****************************************
  logic [3:0] live_v;
  logic [3:0] prev_r;
  logic [3:0] flag_r;
  logic [3:0] set_v;
  logic       mark_r;
  logic       mark_hit;

  assign live_v = {q_overflow, src.parity_fault, src.overrange, src.undervolt};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_latch
      // Edge mode needs the previous level; level mode re-sets every cycle
      assign set_v[gi] = edge_latch_select ? (live_v[gi] && !prev_r[gi])
                                           : live_v[gi];
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          prev_r[gi] <= 1'b0;
          flag_r[gi] <= 1'b0;
        end else begin
          prev_r[gi] <= live_v[gi];
          // A new event in the clearing cycle survives
          flag_r[gi] <= set_v[gi] || (flag_r[gi] && !status_read);
        end
      end
    end
  endgenerate

  assign undervolt_latched = flag_r[0];
  assign overrange_latched = flag_r[1];
  assign parity_latched    = flag_r[2];
  assign overflow_latched  = flag_r[3];

  // Level of zero would mark an empty queue; treated as any depth qualifies
  assign mark_hit = q_run && (queue_count >= mark_level);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mark_r <= 1'b0;
    end else begin
      mark_r <= mark_hit || (mark_r && !mark_read);
    end
  end

  assign level_mark = mark_r;

  // ****************************************
  // Pin routing
  // ****************************************
  logic [7:0] vec_a;
  logic [7:0] vec_b;
  logic [7:0] en_a_a;
  logic [7:0] en_b_a;
  logic       or_a;
  logic       or_b;

  // Same source ordering serves both first map registers
  assign vec_a = {src.fuse_busy, src.still, src.motion, 1'b0,
                  mark_r, overflow_latched, queue_full, src.sample_ready};
  // Second map ordering is shared by both pins
  assign vec_b = {src.fuse_done_status, src.fuse_irq, undervolt_latched,
                  overrange_latched, parity_latched, src.tap3, src.tap2, src.tap1};

  function automatic logic [7:0] map_a_en(input logic [7:0] m);
    logic [7:0] e;
    e = m;
    e[`MAPA_RSVD]   = 1'b0;
    e[`MAPA_FULL_N] = !m[`MAPA_FULL_N];
    return e;
  endfunction

  assign en_a_a = map_a_en(pin_a_map_a_r);
  assign en_b_a = map_a_en(irq_pin_b_map_a_r);

  assign or_a = |(vec_a & en_a_a) | |(vec_b & irq_pin_a_map_b_r);
  assign or_b = |(vec_a & en_b_a) | |(vec_b & irq_pin_b_map_b_r);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_pin_a <= 1'b0;
      irq_pin_b <= 1'b0;
    end else begin
      irq_pin_a <= or_a;
      irq_pin_b <= or_b;
    end
  end
endmodule
`default_nettype wire

// ---- tb/irq_route_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_route_monitor
  import irq_route_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       queue_enable,
  input wire logic       edge_latch_select,
  input wire logic       status_read,
  input wire logic       mark_read,
  input wire logic       undervolt_latched,
  input wire logic       overrange_latched,
  input wire logic       level_mark,
  input var event_src_t  src,
  input wire logic [8:0] queue_count,
  input wire logic       queue_full,
  input wire logic       irq_pin_a,
  input wire logic       irq_pin_b
);
  // ****
  // Checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_pins_reset_low: assert property (!$past(rstn) |-> !irq_pin_a && !irq_pin_b)
    else $error("pin high right after reset");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_uv_clears: assert property (status_read && !src.undervolt |=> !undervolt_latched)
    else $error("latched flag survived a clear");
  a_uv_level_set: assert property (!edge_latch_select && src.undervolt |=> undervolt_latched)
    else $error("level mode flag not set");
  a_ovr_level_set: assert property (!edge_latch_select && src.overrange |=> overrange_latched)
    else $error("overrange flag not set");
  a_uv_edge_only: assert property ($past(rstn) && edge_latch_select && status_read
    && src.undervolt && $past(src.undervolt) |=> !undervolt_latched)
    else $error("edge mode flag set without a rise");
  a_full_at_depth: assert property (queue_full == (queue_count == 9'h140))
    else $error("full flag disagrees with count");
  a_off_frozen: assert property (!$past(queue_enable) && $past(rstn)
    |-> queue_count <= $past(queue_count))
    else $error("count grew while queue off");
  a_mark_sticky: assert property (level_mark && !mark_read |=> level_mark)
    else $error("watermark dropped without a read");
endmodule
bind irq_route irq_route_monitor irq_route_monitor_inst (.core_clk, .rstn, .reg_rd,
  .reg_rdata, .queue_enable, .edge_latch_select, .status_read, .mark_read,
  .undervolt_latched, .overrange_latched, .level_mark, .src, .queue_count, .queue_full,
  .irq_pin_a, .irq_pin_b);
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic  core_clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  output logic       status_read,
  output logic       mark_read,
  output logic       look
);
  // ****
  // Host side
  // ****
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, status_read, mark_read, look} = '0;
  end
  // Data bus shows the inverse once released, never the stale byte
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'b00;
    reg_wdata <= ~d;
  endtask
  // Flags only drop when the host reads them
  task automatic pulse(input logic [2:0] s);
    @(posedge core_clk);
    {look, status_read, mark_read} <= s;
    @(posedge core_clk);
    {look, status_read, mark_read} <= 3'b000;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import irq_route_pkg::*;
;
  logic        core_clk, rstn, reg_wr, reg_rd, status_read, mark_read, look;
  logic        queue_enable, edge_latch_select, frame_sync_input, sample_push, queue_pop;
  logic        undervolt_latched, overrange_latched, parity_latched, overflow_latched;
  logic        level_mark, queue_full, irq_pin_a, irq_pin_b, rd_d, look_d, pop_d;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ra[7], rv[7];
  logic [1:0]  sample_tag;
  logic [15:0] sample_data;
  logic [17:0] queue_rdata, exp_q[$];
  logic [8:0]  queue_count;
  logic [31:0] seed, m, r;
  event_src_t  src;
  int          n_errors = 0;
  int          checked = 0;

  irq_route irq_route_inst (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .queue_enable, .edge_latch_select, .status_read, .mark_read,
    .undervolt_latched, .overrange_latched, .parity_latched, .overflow_latched, .level_mark,
    .src, .frame_sync_input, .sample_push, .sample_tag, .sample_data, .queue_pop,
    .queue_rdata, .queue_count, .queue_full, .irq_pin_a, .irq_pin_b);
  host_model host_model_inst (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .status_read, .mark_read, .look);

  // ****
  // Helpers
  // ****
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pin(input logic [7:0] m0, input logic [7:0] m1, input event_src_t s);
    return |(m0 & {s[11], s[1], s[2], 4'h0, s[0]}) | |(m1 & s[10:3]);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({10'h0, e});
    host_model_inst.acc(1'b0, a, 8'h00);
  endtask
  task automatic pins(input logic [1:0] e);
    exp_q.push_back({16'h0, e});
    host_model_inst.pulse(3'b100);
  endtask
  task automatic put(input int n, input logic [17:0] w);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      sample_push <= 1'b1;
      {sample_tag, sample_data} <= w + 18'(i);
    end
    @(posedge core_clk);
    sample_push <= 1'b0;
  endtask
  task automatic take(input logic [17:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    queue_pop <= 1'b1;
    @(posedge core_clk);
    queue_pop <= 1'b0;
  endtask

  // ****
  // Clock, watcher, watchdog
  // ****
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rd_d   <= reg_rd;
    look_d <= look;
    pop_d  <= queue_pop;
  end
  always @(negedge core_clk) begin
    if ((rd_d || look_d || pop_d) && exp_q.size() > 0) begin
      check(rd_d ? {10'h0, reg_rdata} : look_d ? {16'h0, irq_pin_a, irq_pin_b} : queue_rdata,
        exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    {src, queue_enable, edge_latch_select, frame_sync_input} = '0;
    {sample_push, queue_pop, sample_tag, sample_data, rstn} = '0;
    seed = 32'h00015424;
    ra = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'h2f};
    rv = '{8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'hf9);
    wr(8'h2f, 8'hff);
    rd(8'h2f, 8'h00);
    wr(8'h30, 8'h80);
    // Queue off here, so only live and latched sources reach the pins
    for (int i = 0; i < 40; i++) begin
      m = rnd();
      for (int k = 0; k < 4; k++) wr(ra[k], m[8*k +: 8]);
      r = rnd();
      src <= event_src_t'(r[11:0]);
      host_model_inst.pulse(3'b010);
      pins({pin(m[7:0], m[15:8], r[11:0]), pin(m[23:16], m[31:24], r[11:0])});
      rd(8'h2d, m[23:16]);
    end
    for (int k = 0; k < 4; k++) wr(ra[k], k == 1 ? 8'h20 : 8'h00);
    src <= '0;
    edge_latch_select <= 1'b1;
    host_model_inst.pulse(3'b010);
    src.undervolt <= 1'b1;
    pins(2'b10);
    host_model_inst.pulse(3'b010);
    pins(2'b00);
    for (int i = 0; i < 5; i++) begin
      queue_enable <= i < 4;
      wr(8'h30, 8'h80);
      wr(8'h30, i == 4 ? 8'h10 : 8'(i << 4));
      put(1, 18'h0);
      rd(8'h31, 8'h00);
      check(18'(queue_count), 18'(i > 0 && i < 4));
    end
    // Last loop pass left the queue off; level zero also left the mark set
    queue_enable <= 1'b1;
    wr(8'h30, 8'h80);
    wr(8'h31, 8'h03);
    wr(8'h30, 8'h50);
    host_model_inst.pulse(3'b001);
    @(posedge core_clk);
    check(18'(level_mark), 18'h0);
    put(3, 18'h2a5a0);
    repeat (2) @(posedge core_clk);
    check(18'(level_mark), 18'h1);
    take(18'h2a5a0);
    wr(8'h30, 8'h10);
    take(18'h0a5a1);
    check(18'(level_mark), 18'h1);
    host_model_inst.pulse(3'b001);
    @(posedge core_clk);
    check(18'(level_mark), 18'h0);
    wr(8'h30, 8'h80);
    wr(8'h30, 8'h10);
    put(321, 18'h0);
    repeat (2) @(posedge core_clk);
    check({queue_full, overflow_latched}, 18'h3);
    wr(8'h2b, 8'h02);
    wr(8'h2c, 8'h00);
    wr(8'h2e, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(8'h2d, k == 0 ? 8'h00 : k == 1 ? 8'h02 : 8'h06);
      pins({1'b0, k != 1});
    end
    // Armed trigger mode overwrites when full; frame sync starts capture
    wr(8'h30, 8'h38);
    host_model_inst.pulse(3'b010);
    put(1, 18'h0);
    repeat (2) @(posedge core_clk);
    check(18'(overflow_latched), 18'h0);
    frame_sync_input <= 1'b1;
    put(1, 18'h0);
    repeat (2) @(posedge core_clk);
    check(18'(overflow_latched), 18'h1);
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
